// [ibl_blink.sv]
// Free-running square-wave generator with a variable half period
`timescale 1ns/100ps
`default_nettype none
module ibl_blink
  import ibl_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [CNT_W-1:0] i_half_cyc,
  output logic                  o_wave
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             wave_r;
  logic             wave_nxt;

  always_comb begin
    cnt_nxt  = cnt_r + 26'h1;
    wave_nxt = wave_r;
    if (cnt_r + 26'h1 >= i_half_cyc) begin
      cnt_nxt  = CNT_ZERO;
      wave_nxt = ~wave_r;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_r  <= CNT_ZERO;
      wave_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign o_wave = wave_r;
endmodule
`default_nettype wire

// [ibl_ctrl.sv]
// Indicator controller: mode button, default restore and LED patterns
`timescale 1ns/100ps
`default_nettype none
module ibl_ctrl
  import ibl_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_button,
  input  wire ibl_rx_status_t  i_status,
  input  wire logic [CN_W-1:0] i_cn,
  input  wire logic            i_utc_tick,
  output logic                 o_restore_defaults,
  output logic                 o_keep_channel_sel,
  output logic                 o_keep_second_setting_a,
  output logic                 o_quality_mode,
  output ibl_leds_t            o_leds
);
  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // True on the last cycle of a count that runs up from zero to lim
  function automatic logic cnt_done(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] lim);
    return (cnt + 26'h1) >= lim;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  ibl_rx_status_t st_s;
  logic           btn_s;
  logic           tick_s;
  logic [CN_W-1:0] cn_s;

  ibl_sync #(.W(9)) u_sync_lvl (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_button, i_utc_tick, i_status}),
    .o_sync    ({btn_s, tick_s, st_s})
  );

  // C/N word; torn samples are filtered by the capture stage below
  ibl_sync #(.W(CN_W)) u_sync_cn (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_cn),
    .o_sync    (cn_s)
  );

  // Multi-bit estimate may be caught mid-change; a value is taken only
  // once two successive synchronised samples agree
  logic [CN_W-1:0] cn_prev_r, cn_prev_nxt;
  logic [CN_W-1:0] cn_r, cn_nxt;

  always_comb begin
    cn_prev_nxt = cn_s;
    cn_nxt      = cn_r;
    if (cn_s == cn_prev_r) begin
      cn_nxt = cn_s;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cn_prev_r <= '0;
      cn_r      <= '0;
    end else begin
      cn_prev_r <= cn_prev_nxt;
      cn_r      <= cn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Button debounce, press classification, mode
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] deb_cnt_r, deb_cnt_nxt;
  logic             btn_r, btn_nxt;
  logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
  logic             held_r, held_nxt;
  ibl_mode_t        mode_r, mode_nxt;
  logic             restore_r, restore_nxt;
  logic             tick_d_r, tick_d_nxt;

  always_comb begin
    deb_cnt_nxt  = deb_cnt_r;
    btn_nxt      = btn_r;
    hold_cnt_nxt = hold_cnt_r;
    held_nxt     = held_r;
    mode_nxt     = mode_r;
    restore_nxt  = 1'b0;
    tick_d_nxt   = tick_s;
    // Level must stay changed for the whole window before it is accepted
    if (btn_s == btn_r) begin
      deb_cnt_nxt = CNT_ZERO;
    end else if (cnt_done(deb_cnt_r, CNT_W'(DEBOUNCE_CYC))) begin
      deb_cnt_nxt = CNT_ZERO;
      btn_nxt     = btn_s;
    end else begin
      deb_cnt_nxt = deb_cnt_r + 26'h1;
    end
    if (btn_r) begin
      if (!held_r) begin
        if (cnt_done(hold_cnt_r, CNT_W'(HOLD_CYC))) begin
          held_nxt    = 1'b1;
          restore_nxt = 1'b1;
        end else begin
          hold_cnt_nxt = hold_cnt_r + 26'h1;
        end
      end
      if (!btn_nxt) begin
        // Release: a hold that restores, even on this very cycle, must not toggle
        if (!held_nxt) begin
          mode_nxt = (mode_r == IBL_MODE_NORMAL) ? IBL_MODE_QUALITY
                                                 : IBL_MODE_NORMAL;
        end
        hold_cnt_nxt = CNT_ZERO;
        held_nxt     = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      deb_cnt_r  <= CNT_ZERO;
      btn_r      <= 1'b0;
      hold_cnt_r <= CNT_ZERO;
      held_r     <= 1'b0;
      mode_r     <= IBL_MODE_NORMAL;
      restore_r  <= 1'b0;
      tick_d_r   <= 1'b0;
    end else begin
      deb_cnt_r  <= deb_cnt_nxt;
      btn_r      <= btn_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      held_r     <= held_nxt;
      mode_r     <= mode_nxt;
      restore_r  <= restore_nxt;
      tick_d_r   <= tick_d_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Independent rate sources
  // ----------------------------------------------------------------
  logic             slow_w, fast_w, qual_w;
  logic [CNT_W-1:0] qual_half;

  always_comb begin
    qual_half = CNT_W'(CN_BASE_CYC / (32'(cn_r) + 32'd1));
  end

  ibl_blink u_slow (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_half_cyc (CNT_W'(SLOW_HALF_CYC)),
    .o_wave     (slow_w)
  );

  ibl_blink u_fast (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_half_cyc (CNT_W'(FAST_HALF_CYC)),
    .o_wave     (fast_w)
  );

  ibl_blink u_qual (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_half_cyc (qual_half),
    .o_wave     (qual_w)
  );

  // ----------------------------------------------------------------
  // UTC pulse, power-up red, acknowledge flashes
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] pulse_cnt_r, pulse_cnt_nxt;
  logic [CNT_W-1:0] pwr_cnt_r, pwr_cnt_nxt;
  logic [CNT_W-1:0] ack_cnt_r, ack_cnt_nxt;
  logic [2:0]       ack_half_r, ack_half_nxt;

  always_comb begin
    pulse_cnt_nxt = (pulse_cnt_r != CNT_ZERO) ? pulse_cnt_r - 26'h1 : CNT_ZERO;
    if (tick_s && !tick_d_r) begin
      pulse_cnt_nxt = CNT_W'(PULSE_ON_CYC);
    end
    pwr_cnt_nxt = (pwr_cnt_r != CNT_ZERO) ? pwr_cnt_r - 26'h1 : CNT_ZERO;
    ack_cnt_nxt  = ack_cnt_r;
    ack_half_nxt = ack_half_r;
    if (ack_half_r != 3'h0) begin
      if (cnt_done(ack_cnt_r, CNT_W'(ACK_HALF_CYC))) begin
        ack_cnt_nxt  = CNT_ZERO;
        ack_half_nxt = ack_half_r - 3'h1;
      end else begin
        ack_cnt_nxt = ack_cnt_r + 26'h1;
      end
    end
    if (restore_r) begin
      ack_cnt_nxt  = CNT_ZERO;
      ack_half_nxt = 3'(2 * ACK_FLASHES);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pulse_cnt_r <= CNT_ZERO;
      pwr_cnt_r   <= CNT_W'(POWERUP_RED_CYC);
      ack_cnt_r   <= CNT_ZERO;
      ack_half_r  <= 3'h0;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
      pwr_cnt_r   <= pwr_cnt_nxt;
      ack_cnt_r   <= ack_cnt_nxt;
      ack_half_r  <= ack_half_nxt;
    end
  end

  // ----------------------------------------------------------------
  // LED selection
  // ----------------------------------------------------------------
  ibl_leds_t leds_r, leds_nxt;
  logic      rest_r, rest_nxt;

  always_comb begin
    leds_nxt = '0;
    rest_nxt = restore_r;
    if (ack_half_r != 3'h0) begin
      // Counting down from six, even halves are lit so the first flash starts at once
      leds_nxt.green = !ack_half_r[0];
      leds_nxt.red   = !ack_half_r[0];
    end else if (mode_r == IBL_MODE_NORMAL) begin
      if (!st_s.sig_detected) begin
        leds_nxt.green = 1'b1;
      end else if (st_s.utc_locked) begin
        leds_nxt.green = (pulse_cnt_r != CNT_ZERO);
      end else if (st_s.locking) begin
        leds_nxt.green = fast_w;
      end else begin
        leds_nxt.green = slow_w;
      end
      leds_nxt.red = (pwr_cnt_r != CNT_ZERO) || st_s.fault;
    end else begin
      if (!st_s.sig_detected) begin
        leds_nxt.green = 1'b0;
      end else if (!(st_s.locking || st_s.utc_locked)) begin
        leds_nxt.green = 1'b1;
      end else begin
        leds_nxt.green = qual_w;
      end
      leds_nxt.red = !st_s.sync_valid || st_s.crc_fail;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      leds_r <= '0;
      rest_r <= 1'b0;
    end else begin
      leds_r <= leds_nxt;
      rest_r <= rest_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mode and preservation flags
  // ----------------------------------------------------------------
  // Preservation flags are flops that reset low and load 1 on every cycle after reset, so every output is registered
  logic keep_r, keep_nxt;
  logic qmode_r, qmode_nxt;

  always_comb begin
    keep_nxt  = 1'b1;
    qmode_nxt = (mode_nxt == IBL_MODE_QUALITY);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      keep_r  <= 1'b0;
      qmode_r <= 1'b0;
    end else begin
      keep_r  <= keep_nxt;
      qmode_r <= qmode_nxt;
    end
  end

  assign o_leds                  = leds_r;
  assign o_restore_defaults      = rest_r;
  assign o_keep_channel_sel      = keep_r;
  assign o_keep_second_setting_a = keep_r;
  assign o_quality_mode          = qmode_r;
endmodule
`default_nettype wire

// [ibl_ctrl_props.sv]
// Checker for the indicator button and LED controller
`timescale 1ns/100ps
`default_nettype none
module ibl_ctrl_chk
  import ibl_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_button,
  input  wire ibl_rx_status_t  i_status,
  input  wire logic [CN_W-1:0] i_cn,
  input  wire logic            i_utc_tick,
  input  wire logic            o_restore_defaults,
  input  wire logic            o_keep_channel_sel,
  input  wire logic            o_keep_second_setting_a,
  input  wire logic            o_quality_mode,
  input  wire ibl_leds_t       o_leds
);
  // Acknowledge flashes override patterns for 1.5 s after a restore
  localparam int unsigned ACK_GUARD = 2 * ACK_FLASHES * ACK_HALF_CYC + 10;
  logic [23:0] ack_cnt_r, ack_cnt_nxt;
  logic [11:0] btn_cnt_r, btn_cnt_nxt;
  logic        calm;
  always_comb begin
    ack_cnt_nxt = ack_cnt_r + {23'h0, ack_cnt_r != 24'hffffff};
    if (o_restore_defaults) ack_cnt_nxt = 24'h0;
    btn_cnt_nxt = i_button ? btn_cnt_r + {11'h0, btn_cnt_r != 12'hfff} : 12'h0;
    if (!i_rst_b) ack_cnt_nxt = 24'hffffff;
  end
  always_ff @(posedge i_sys_clk) begin
    ack_cnt_r <= ack_cnt_nxt;
    btn_cnt_r <= btn_cnt_nxt;
  end
  assign calm = ack_cnt_r >= ACK_GUARD;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Mode settled, inputs quiet long enough to pass the synchronisers
  sequence s_calm(q, c);
    (o_quality_mode == q && calm && c && $stable(i_status))[*6];
  endsequence
  a_keep_flags_set: assert property (
    $past(i_rst_b) |-> o_keep_channel_sel && o_keep_second_setting_a)
    else $error("keep flags low");
  a_restore_after_hold: assert property (
    o_restore_defaults |-> btn_cnt_r == 12'hfff)
    else $error("restore without long hold");
  a_restore_one_pulse: assert property (
    o_restore_defaults |=> !o_restore_defaults)
    else $error("restore pulse too long");
  a_ack_both_on: assert property (
    o_restore_defaults |-> ##[0:4] o_leds == 2'b11)
    else $error("no joint flash after restore");
  a_start_normal: assert property (
    $rose(i_rst_b) |-> !o_quality_mode)
    else $error("not normal after reset");
  a_toggle_on_release: assert property (
    $changed(o_quality_mode) |-> !$past(i_button, 4) && !$past(i_button, 8))
    else $error("mode changed while pressed");
  a_normal_green_nosig: assert property (
    s_calm(1'b0, !i_status.sig_detected) |-> o_leds.green)
    else $error("normal green not steady");
  a_normal_red_fault: assert property (
    s_calm(1'b0, i_status.fault) |-> o_leds.red)
    else $error("fault without red");
  a_qual_green_off: assert property (
    s_calm(1'b1, !i_status.sig_detected) |-> !o_leds.green)
    else $error("quality green not off");
  a_qual_green_on: assert property (
    s_calm(1'b1, i_status.sig_detected && !i_status.locking && !i_status.utc_locked)
    |-> o_leds.green)
    else $error("quality green not on");
  a_qual_red_sync: assert property (
    s_calm(1'b1, 1'b1) |-> o_leds.red == (!i_status.sync_valid || i_status.crc_fail))
    else $error("quality red wrong");
  a_utc_pulse: assert property (
    !o_quality_mode && calm && $past(i_status.utc_locked, 4) && $rose(i_utc_tick)
    |-> ##[2:8] o_leds.green)
    else $error("no pulse on tick");
endmodule
bind ibl_ctrl ibl_ctrl_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_button(i_button), .i_status(i_status),
  .i_cn(i_cn), .i_utc_tick(i_utc_tick), .o_restore_defaults(o_restore_defaults),
  .o_keep_channel_sel(o_keep_channel_sel), .o_keep_second_setting_a(o_keep_second_setting_a),
  .o_quality_mode(o_quality_mode), .o_leds(o_leds)
);
`default_nettype wire

// [ibl_operator.sv]
// Operator model that works the mode button
`timescale 1ns/100ps
`default_nettype none
module ibl_operator (
  input  wire logic i_sys_clk,
  output logic      o_button
);
  initial o_button = 1'b0;
  // Button has no pull: released means a clean low, held means a clean high
  task automatic press(input int unsigned cyc);
    @(posedge i_sys_clk);
    o_button <= 1'b1;
    repeat (cyc) @(posedge i_sys_clk);
    o_button <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [ibl_pkg.sv]
// Package: constants and carrier types for the indicator button and LED controller
package ibl_pkg;
  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10000000;
  localparam int unsigned HOLD_TIME_S      = 5;
  localparam int unsigned DEBOUNCE_TIME_MS = 20;
  localparam int unsigned SLOW_PERIOD_MS   = 2500;   // About 0.4 Hz
  localparam int unsigned FAST_PERIOD_MS   = 166;    // About 6 Hz, period rounded down
  localparam int unsigned PULSE_ON_MS      = 100;    // Short on time of the 1 Hz pulse
  localparam int unsigned ACK_HALF_MS      = 250;    // Half period of one acknowledge flash
  localparam int unsigned POWERUP_RED_MS   = 500;    // Brief red at power-up

  localparam int unsigned HOLD_CYC     = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_HALF_CYC = SLOW_PERIOD_MS * (CLK_HZ / 1000) / 2;
  localparam int unsigned FAST_HALF_CYC = FAST_PERIOD_MS * (CLK_HZ / 1000) / 2;
  localparam int unsigned PULSE_ON_CYC  = PULSE_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned ACK_HALF_CYC  = ACK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned POWERUP_RED_CYC = POWERUP_RED_MS * (CLK_HZ / 1000);

  localparam int unsigned ACK_FLASHES = 3;
  localparam int unsigned CNT_W       = 26;
  localparam int unsigned CN_W        = 8;
  // Quality toggle half period is CN_BASE_CYC / (cn + 1): faster for stronger signal
  localparam int unsigned CN_BASE_CYC = 2 * CLK_HZ;

  localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sig_detected;
    logic locking;
    logic decoded;
    logic utc_locked;
    logic fault;
    logic sync_valid;
    logic crc_fail;
  } ibl_rx_status_t;

  typedef struct packed {
    logic green;
    logic red;
  } ibl_leds_t;

  typedef enum logic {IBL_MODE_NORMAL, IBL_MODE_QUALITY} ibl_mode_t;
endpackage

// [ibl_sync.sv]
// Two-stage synchroniser for external level inputs
`timescale 1ns/100ps
`default_nettype none
module ibl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule
`default_nettype wire

// [indicator_button_led_control_test.sv]
// Self-checking testbench for the indicator controller
`timescale 1ns/100ps
`default_nettype none
module indicator_button_led_control_test
  import ibl_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst_b;
  logic           btn;
  ibl_rx_status_t st;
  logic [7:0]     cn;
  logic           tick;
  logic           rst_pl, keep_ch, keep_sec, qmode;
  ibl_leds_t      leds;
  int             errors = 0;
  int             n_checks = 0;
  int             n_restore = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (rst_pl === 1'b1) n_restore++;
  ibl_operator op (.i_sys_clk(clk), .o_button(btn));
  ibl_ctrl dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_button(btn), .i_status(st), .i_cn(cn),
    .i_utc_tick(tick), .o_restore_defaults(rst_pl), .o_keep_channel_sel(keep_ch),
    .o_keep_second_setting_a(keep_sec), .o_quality_mode(qmode), .o_leds(leds)
  );
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic chk_ok(input bit ok, input string what);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic set_st(input ibl_rx_status_t s);
    @(posedge clk);
    st <= s;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic count_tog(input int cyc, output int n);
    logic prev;
    n = 0;
    prev = leds.green;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (leds.green !== prev) n++;
      prev = leds.green;
    end
  endtask
  task automatic t_reset();
    @(posedge clk);
    #1;
    chk_bit(qmode, 1'b0, "mode after reset");
    chk_bit(keep_ch & keep_sec, 1'b1, "keep flags");
    chk_bit(leds.red, 1'b1, "power-up red");
    chk_bit(leds.green, 1'b1, "green without signal");
  endtask
  // A short blip must never reach the mode logic
  task automatic t_bounce();
    op.press(1000);
    repeat (5000) @(posedge clk);
    #1;
    chk_bit(qmode, 1'b0, "blip toggled mode");
  endtask
  task automatic t_toggle(input logic exp);
    op.press(250000);
    for (int i = 0; i < 260000 && qmode !== exp; i++) @(posedge clk);
    #1;
    chk_bit(qmode, exp, "mode toggle");
    chk_ok(n_restore == 0, "short press restored");
  endtask
  task automatic t_quality();
    set_st(7'h00);
    chk_bit(leds.green, 1'b0, "quality green off");
    set_st(7'h40);
    chk_bit(leds.green, 1'b1, "quality green on");
    for (int i = 0; i < 4; i++) begin
      set_st({5'h10, i[1:0]});
      chk_bit(leds.red, !i[1] | i[0], "quality red");
    end
  endtask
  task automatic t_cn();
    int n;
    @(posedge clk);
    cn <= 8'hff;
    set_st(7'h62);
    count_tog(160000, n);
    chk_ok(n >= 2, "strong signal too slow");
    @(posedge clk);
    cn <= 8'h00;
    count_tog(160000, n);
    chk_ok(n <= 1, "weak signal too fast");
  endtask
  task automatic t_utc();
    set_st(7'h5a);
    chk_bit(leds.green, 1'b0, "green before tick");
    @(posedge clk);
    tick <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk_bit(leds.green, 1'b1, "green on tick");
    @(posedge clk);
    tick <= 1'b0;
  endtask
  initial begin
    rst_b = 1'b0;
    st = '0;
    cn = 8'h00;
    tick = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bounce();
    t_toggle(1'b1);
    t_quality();
    t_cn();
    t_toggle(1'b0);
    t_utc();
    end_sim();
  end
  // Whole sequence needs about 1.23 million cycles
  initial begin
    #200000000;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
